// ### core/srp_host.sv
// Host end: Wishbone classic slave, transmit FIFO and serial link master.
// Assumes the device resynchronises the link; the serial clock is divided here.
`timescale 1ns/1ps
`default_nettype none
`include "srp_consts.svh"

module srp_fifo #(
	parameter int WIDTH = 8,	// Word width
	parameter int DEPTH = 16	// Entries, power of two
) (
	input  wire logic             clock,     // System clock
	input  wire logic             reset_n,   // Synchronous reset
	input  wire logic             in_valid,  // Word offered
	output logic                  in_ready,  // Room available
	input  wire logic [WIDTH-1:0] in_data,   // Word in
	output logic                  out_valid, // Word available
	input  wire logic             out_ready, // Word taken
	output logic [WIDTH-1:0]      out_data   // Word out
);
	import srp_pkg::*;
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [0:DEPTH-1];
	logic [AW:0]      wp_r;
	logic [AW:0]      rp_r;

	// Extra pointer bit separates full from empty
	assign in_ready  = (wp_r - rp_r) != (AW+1)'(DEPTH);
	assign out_valid = wp_r != rp_r;
	assign out_data  = mem_r[rp_r[AW-1:0]];

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (in_valid && in_ready)
				wp_r <= wp_r + 1'b1;
			if (out_valid && out_ready)
				rp_r <= rp_r + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (in_valid && in_ready)
			mem_r[wp_r[AW-1:0]] <= in_data;
	end
endmodule : srp_fifo

module srp_host #(
	parameter int HALF       = `SRP_SCLK_HALF,	// System cycles per serial half period
	parameter int WAD_CYCLES = `SRP_WAD_CYCLES,	// Power-up write hold-off
	parameter int FIFO_DEPTH = `SRP_FIFO_DEPTH	// Transmit FIFO entries
) (
	input  wire logic        clock,    // System clock
	input  wire logic        reset_n,  // Synchronous reset
	input  wire logic        wb_cyc_i, // Bus cycle
	input  wire logic        wb_stb_i, // Strobe
	input  wire logic        wb_we_i,  // Write
	input  wire logic [7:0]  wb_adr_i, // Byte address
	input  wire logic [31:0] wb_dat_i, // Write data
	input  wire logic [3:0]  wb_sel_i, // Byte lanes
	output logic [31:0]      wb_dat_o, // Read data
	output logic             wb_ack_o, // Acknowledge
	srp_spi_if.host          spi       // Serial link
);
	import srp_pkg::*;
	srp_hst_t    st_r;
	srp_cmd_t    cmd_r;
	logic [7:0]  ph_r, tx_sh_r, rx_sh_r, rx_data_r, byte_val, f_data;
	logic [2:0]  bit_r;
	logic [8:0]  bcnt_r, len_r;
	logic [23:0] addr_r;
	logic [31:0] dat_r, rd_mux, wad_cnt_r;
	logic        ack_r, pend_r, wad_done_r, rx_valid_r, sclk_r, cs_n_r, si_r;
	logic        so1_r, so2_r, so3_r, so_f_r;
	logic        push_req, take, wr, start, eng_busy, stall, last_ph, rx_set, rx_clr;
	logic        f_in_valid, f_in_ready, f_valid, f_ready, active;

	assign wb_dat_o = dat_r;
	assign wb_ack_o = ack_r;
	assign spi.cs_n = cs_n_r;
	assign spi.sclk = sclk_r;
	assign spi.si   = si_r;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			so1_r  <= 1'b0;
			so2_r  <= 1'b0;
			so3_r  <= 1'b0;
			so_f_r <= 1'b0;
		end else begin
			so1_r <= spi.so;
			so2_r <= so1_r;
			so3_r <= so2_r;
			if (so2_r == so3_r)
				so_f_r <= so3_r;
		end
	end

	// Full FIFO holds off the acknowledge, so software is stalled, not dropped
	assign push_req   = wb_we_i && wb_adr_i == `SRP_A_TXDATA && wb_sel_i[0];
	assign f_in_valid = wb_cyc_i && wb_stb_i && !ack_r && push_req;
	assign take       = wb_cyc_i && wb_stb_i && !ack_r && (!push_req || f_in_ready);
	assign wr         = take && wb_we_i;
	assign rx_clr     = take && !wb_we_i && wb_adr_i == `SRP_A_RXDATA;
	assign eng_busy   = pend_r || st_r != srp_h_idle;
	// Write-type commands wait out the power-up hold-off
	assign start = pend_r && st_r == srp_h_idle &&
		(wad_done_r || cmd_r == srp_cmd_read || cmd_r == srp_cmd_rdsr);

	srp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txf (
		.clock     (clock),
		.reset_n   (reset_n),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   (wb_dat_i[7:0]),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);

	always_comb begin
		case (wb_adr_i)
			`SRP_A_CTRL:   rd_mux = {29'h0, cmd_r, eng_busy};
			`SRP_A_ADDR:   rd_mux = {8'h00, addr_r};
			`SRP_A_LEN:    rd_mux = {23'h0, len_r};
			`SRP_A_RXDATA: rd_mux = {24'h0, rx_data_r};
			`SRP_A_STATUS: rd_mux = {28'h0, f_in_ready, rx_valid_r, wad_done_r, eng_busy};
			default:       rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ack_r  <= 1'b0;
			dat_r  <= 32'h0;
			addr_r <= 24'h0;
			len_r  <= 9'h001;
			cmd_r  <= srp_cmd_wren;
			pend_r <= 1'b0;
		end else begin
			ack_r <= take;
			if (take && !wb_we_i)
				dat_r <= rd_mux;
			if (start)
				pend_r <= 1'b0;
			if (wr && !eng_busy) begin
				case (wb_adr_i)
					`SRP_A_CTRL: begin
						if (wb_sel_i[0]) begin
							cmd_r  <= srp_cmd_t'(wb_dat_i[2:1]);
							pend_r <= wb_dat_i[0];
						end
					end
					`SRP_A_ADDR: begin
						for (int k = 0; k < 3; k++)
							if (wb_sel_i[k])
								addr_r[k*8 +: 8] <= wb_dat_i[k*8 +: 8];
					end
					`SRP_A_LEN: begin
						if (wb_sel_i[0] && wb_sel_i[1])
							len_r <= wb_dat_i[8:0];
					end
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			wad_cnt_r  <= 32'h0;
			wad_done_r <= 1'b0;
		end else if (!wad_done_r) begin
			wad_cnt_r <= wad_cnt_r + 32'h1;
			if (wad_cnt_r == 32'(WAD_CYCLES - 1))
				wad_done_r <= 1'b1;
		end
	end

	always_comb begin
		case (st_r)
			srp_h_op: begin
				case (cmd_r)
					srp_cmd_wren: byte_val = `SRP_OP_WREN;
					srp_cmd_prog: byte_val = `SRP_OP_PROG;
					srp_cmd_read: byte_val = `SRP_OP_READ;
					default:      byte_val = `SRP_OP_RDSR;
				endcase
			end
			srp_h_addr: begin
				if (bcnt_r == 9'h2)
					byte_val = addr_r[23:16];
				else if (bcnt_r == 9'h1)
					byte_val = addr_r[15:8];
				else
					byte_val = addr_r[7:0];
			end
			srp_h_tx: byte_val = f_data;
			default:  byte_val = 8'h00;
		endcase
	end

	assign active  = st_r != srp_h_idle && st_r != srp_h_gap;
	assign stall   = (st_r == srp_h_tx && !f_valid) || (st_r == srp_h_rx && rx_valid_r);
	assign f_ready = st_r == srp_h_tx && ph_r == 8'h00 && bit_r == 3'h0;
	assign last_ph = ph_r == 8'(2 * HALF - 1);
	assign rx_set  = st_r == srp_h_rx && last_ph && bit_r == 3'h7;

	// Select stays low across the whole command; bytes end on whole boundaries
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			st_r    <= srp_h_idle;
			ph_r    <= 8'h00;
			bit_r   <= 3'h0;
			bcnt_r  <= 9'h0;
			tx_sh_r <= 8'h00;
			rx_sh_r <= 8'h00;
			sclk_r  <= 1'b0;
			cs_n_r  <= 1'b1;
			si_r    <= 1'b0;
		end else if (st_r == srp_h_idle) begin
			if (start) begin
				cs_n_r <= 1'b0;
				st_r   <= srp_h_op;
				ph_r   <= 8'h00;
				bit_r  <= 3'h0;
			end
		end else if (st_r == srp_h_gap) begin
			cs_n_r <= 1'b1;
			ph_r   <= ph_r + 8'h01;
			if (last_ph)
				st_r <= srp_h_idle;
		end else if (active) begin
			if (!(ph_r == 8'h00 && bit_r == 3'h0 && stall))
				ph_r <= last_ph ? 8'h00 : ph_r + 8'h01;
			if (ph_r == 8'h00 && !(bit_r == 3'h0 && stall)) begin
				if (bit_r == 3'h0) begin
					si_r    <= byte_val[7];
					tx_sh_r <= {byte_val[6:0], 1'b0};
				end else begin
					si_r    <= tx_sh_r[7];
					tx_sh_r <= {tx_sh_r[6:0], 1'b0};
				end
			end
			if (ph_r == 8'(HALF)) begin
				sclk_r  <= 1'b1;
				rx_sh_r <= {rx_sh_r[6:0], so_f_r};
			end
			if (last_ph) begin
				sclk_r <= 1'b0;
				bit_r  <= bit_r + 3'h1;
				if (bit_r == 3'h7) begin
					case (st_r)
						srp_h_op: begin
							if (cmd_r == srp_cmd_wren)
								st_r <= srp_h_gap;
							else if (cmd_r == srp_cmd_rdsr) begin
								st_r   <= srp_h_rx;
								bcnt_r <= 9'h0;
							end else begin
								st_r   <= srp_h_addr;
								bcnt_r <= 9'h2;
							end
						end
						srp_h_addr: begin
							if (bcnt_r == 9'h0) begin
								st_r   <= cmd_r == srp_cmd_read ? srp_h_dummy : srp_h_tx;
								bcnt_r <= len_r - 9'h1;
							end else
								bcnt_r <= bcnt_r - 9'h1;
						end
						srp_h_dummy: st_r <= srp_h_rx;
						default: begin
							if (bcnt_r == 9'h0)
								st_r <= srp_h_gap;
							else
								bcnt_r <= bcnt_r - 9'h1;
						end
					endcase
				end
			end
		end
	end

	// A new byte overrides a simultaneous software clear
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rx_valid_r <= 1'b0;
			rx_data_r  <= 8'h00;
		end else begin
			if (rx_set)
				rx_data_r <= rx_sh_r;
			rx_valid_r <= rx_set || (rx_valid_r && !rx_clr);
		end
	end
endmodule : srp_host
`default_nettype wire

// ### core/srp_consts.svh
// Constants shared by both ends of the security-register serial link.
// Included by bare name; holds definitions only.
`ifndef SRP_CONSTS_SVH
`define SRP_CONSTS_SVH

`define SRP_OP_WREN     8'h06
`define SRP_OP_RDSR     8'h05
`define SRP_OP_PROG     8'h42
`define SRP_OP_READ     8'h48

`define SRP_CLK_MHZ     250
`define SRP_WAD_MS      10
`define SRP_WAD_CYCLES  (`SRP_WAD_MS * 1000 * `SRP_CLK_MHZ)
`define SRP_PROG_CYCLES 1024
`define SRP_SCLK_HALF   16
`define SRP_REG_BYTES   256
`define SRP_NREGS       3
`define SRP_FIFO_DEPTH  16

`define SRP_ST_BUSY     0
`define SRP_ST_WLATCH   1
`define SRP_ST_LOCK     2
`define SRP_LOCK_RST    3'h0

`define SRP_A_CTRL      8'h00
`define SRP_A_ADDR      8'h04
`define SRP_A_LEN       8'h08
`define SRP_A_TXDATA    8'h0c
`define SRP_A_RXDATA    8'h10
`define SRP_A_STATUS    8'h14

`endif

// ### core/srp_pkg.sv
// Types shared by both ends of the security-register serial link.
// No timing or clock assumptions.
package srp_pkg;

	typedef enum logic [1:0] {
		srp_cmd_wren = 2'b00,
		srp_cmd_prog = 2'b01,
		srp_cmd_read = 2'b10,
		srp_cmd_rdsr = 2'b11
	} srp_cmd_t;

	typedef enum logic [2:0] {
		srp_d_op    = 3'b000,
		srp_d_addr  = 3'b001,
		srp_d_dummy = 3'b010,
		srp_d_rdata = 3'b011,
		srp_d_pdata = 3'b100,
		srp_d_stat  = 3'b101,
		srp_d_ign   = 3'b110
	} srp_dst_t;

	typedef enum logic [2:0] {
		srp_h_idle  = 3'b000,
		srp_h_op    = 3'b001,
		srp_h_addr  = 3'b010,
		srp_h_dummy = 3'b011,
		srp_h_tx    = 3'b100,
		srp_h_rx    = 3'b101,
		srp_h_gap   = 3'b110
	} srp_hst_t;

endpackage : srp_pkg

// ### core/srp_spi_if.sv
// Serial link between the host controller and the security-register device.
// Plain wires; each end resynchronises what it receives.
`timescale 1ns/1ps
`default_nettype none
interface srp_spi_if;
	logic cs_n;
	logic sclk;
	logic si;
	logic so;
	logic so_oe_n;

	modport dev  (input cs_n, input sclk, input si, output so, output so_oe_n);
	modport host (output cs_n, output sclk, output si, input so, input so_oe_n);
endinterface : srp_spi_if
`default_nettype wire

// ### core/srp_dev.sv
// Device end: three one-time-lockable 256-byte security registers on a serial link.
// Assumes the host drives select, clock and serial input asynchronously to clock.
//
// Functional notes
// - Program is 42h, 24-bit address, data bytes.
// - Program accepted only with write enable latch set.
// - One to 256 bytes; target erased locations.
// - Host holds select low through whole program.
// - Address selects register 1-3 and byte.
// - Program to a locked register is ignored.
// - Three lock bits, never cleared once set.
// - Read is 48h, 24-bit address, eight dummy clocks.
// - Opcode and address sampled on rising clock.
// - Read data changes on falling clock, MSB first.
// - Read address increments, wraps FFh to 00h.
// - Read runs until select goes high.
// - Read while busy is ignored, cycle unaffected.
// - Host waits write-accept delay before writes.
// - Busy is 1 during self-timed cycle, else 0.
`timescale 1ns/1ps
`default_nettype none
`include "srp_consts.svh"

module srp_dev #(
	parameter int PROG_CYCLES = `SRP_PROG_CYCLES	// Self-timed program length, 256..65536
) (
	input  wire logic       clock,              // System clock
	input  wire logic       reset_n,            // Power-up reset
	input  wire logic [2:0] lock_set,           // Pulse per bit: lock that register
	output logic [2:0]      otp_lock_bits,      // Lock state per register
	output logic            busy,               // Self-timed cycle running
	output logic            write_enable_latch, // Write enable latch
	srp_spi_if.dev          spi                 // Serial link
);
	import srp_pkg::*;
	localparam int NB = `SRP_REG_BYTES;

	logic [2:0]  s1_r, s2_r, s3_r, f_r, fp_r;
	logic        csn, si, rise, fall, cs_rise, byte_done;
	srp_dst_t    st_r;
	logic [2:0]  bitc_r, obit_r, lock_r;
	logic [7:0]  sh_r, out_sh_r, byte_r, nb, status;
	logic [15:0] addr_r, cnt_r;
	logic [23:0] full;
	logic [1:0]  acnt_r, reg_r, preg_r, sel;
	logic        rd_r, got_r, busy_r, wlatch_r, so_r, so_oe_n_r;
	logic        aok, wren_ok, prog_ok, prog_last, is_out;
	logic [7:0]  mem_r [0:`SRP_NREGS*NB-1];
	logic [7:0]  stage_r [0:NB-1];
	logic [NB-1:0] sval_r;

	assign otp_lock_bits      = lock_r;
	assign busy               = busy_r;
	assign write_enable_latch = wlatch_r;
	assign spi.so             = so_r;
	assign spi.so_oe_n        = so_oe_n_r;

	// Three-stage resync; a level counts once stages two and three agree
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			s1_r <= 3'h4;
			s2_r <= 3'h4;
			s3_r <= 3'h4;
			f_r  <= 3'h4;
			fp_r <= 3'h4;
		end else begin
			s1_r <= {spi.cs_n, spi.sclk, spi.si};
			s2_r <= s1_r;
			s3_r <= s2_r;
			f_r  <= (s2_r & s3_r) | (f_r & (s2_r | s3_r));
			fp_r <= f_r;
		end
	end

	assign csn       = f_r[2];
	assign si        = f_r[0];
	assign rise      = !csn && f_r[1] && !fp_r[1];
	assign fall      = !csn && !f_r[1] && fp_r[1];
	assign cs_rise   = f_r[2] && !fp_r[2];
	assign byte_done = rise && bitc_r == 3'h7;
	assign nb        = {sh_r[6:0], si};
	assign full      = {addr_r, nb};
	// Upper byte and bits 11:8 zero, bits 15:12 one of 1..3
	assign aok = full[23:16] == 8'h00 && full[11:8] == 4'h0 &&
		full[15:14] == 2'b00 && full[13:12] != 2'b00;
	assign sel       = full[13:12] - 2'h1;
	assign wren_ok   = byte_done && st_r == srp_d_op && nb == `SRP_OP_WREN && !busy_r;
	assign prog_ok   = byte_done && st_r == srp_d_op && nb == `SRP_OP_PROG &&
		!busy_r && wlatch_r;
	assign prog_last = busy_r && cnt_r == 16'(PROG_CYCLES - 1);
	assign is_out    = st_r == srp_d_rdata || st_r == srp_d_stat;
	assign status    = (8'(busy_r) << `SRP_ST_BUSY) | (8'(wlatch_r) << `SRP_ST_WLATCH) |
		(8'(lock_r) << `SRP_ST_LOCK);

	// Command decoder, bits taken on the rising serial clock
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			st_r   <= srp_d_op;
			bitc_r <= 3'h0;
			sh_r   <= 8'h00;
			addr_r <= 16'h0;
			acnt_r <= 2'h0;
			rd_r   <= 1'b0;
			byte_r <= 8'h00;
			reg_r  <= 2'h0;
			got_r  <= 1'b0;
		end else if (csn) begin
			st_r   <= srp_d_op;
			bitc_r <= 3'h0;
			acnt_r <= 2'h0;
		end else if (rise) begin
			bitc_r <= bitc_r + 3'h1;
			sh_r   <= nb;
			if (bitc_r == 3'h7) begin
				case (st_r)
					srp_d_op: begin
						rd_r <= nb == `SRP_OP_READ;
						if (nb == `SRP_OP_RDSR)
							st_r <= srp_d_stat;
						else if (prog_ok) begin
							st_r  <= srp_d_addr;
							got_r <= 1'b0;
						end else if (nb == `SRP_OP_READ && !busy_r)
							st_r <= srp_d_addr;
						else
							st_r <= srp_d_ign;
					end
					srp_d_addr: begin
						addr_r <= full[15:0];
						acnt_r <= acnt_r + 2'h1;
						if (acnt_r == 2'h2) begin
							byte_r <= nb;
							reg_r  <= sel;
							if (!aok)
								st_r <= srp_d_ign;
							else if (rd_r)
								st_r <= srp_d_dummy;
							else if (lock_r[sel])
								st_r <= srp_d_ign;
							else
								st_r <= srp_d_pdata;
						end
					end
					srp_d_dummy: begin
						st_r   <= srp_d_rdata;
						byte_r <= byte_r + 8'h01;
					end
					srp_d_pdata: begin
						byte_r <= byte_r + 8'h01;
						got_r  <= 1'b1;
					end
					default: ;
				endcase
			end
		end else if (fall && st_r == srp_d_rdata && obit_r == 3'h7)
			byte_r <= byte_r + 8'h01;
	end

	// Output shifter, updated on the falling serial clock
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			out_sh_r  <= 8'h00;
			obit_r    <= 3'h0;
			so_r      <= 1'b0;
			so_oe_n_r <= 1'b1;
		end else begin
			so_oe_n_r <= !(!csn && is_out);
			if (csn)
				obit_r <= 3'h0;
			else if (byte_done && st_r == srp_d_dummy) begin
				out_sh_r <= mem_r[{reg_r, byte_r}];
				obit_r   <= 3'h0;
			end else if (byte_done && st_r == srp_d_op && nb == `SRP_OP_RDSR) begin
				out_sh_r <= status;
				obit_r   <= 3'h0;
			end else if (fall && is_out) begin
				so_r   <= out_sh_r[7];
				obit_r <= obit_r + 3'h1;
				if (obit_r == 3'h7)
					out_sh_r <= st_r == srp_d_rdata ? mem_r[{reg_r, byte_r}] : status;
				else
					out_sh_r <= {out_sh_r[6:0], 1'b0};
			end
		end
	end

	// Self-timed program cycle
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			busy_r <= 1'b0;
			cnt_r  <= 16'h0;
			preg_r <= 2'h0;
		end else if (busy_r) begin
			cnt_r <= cnt_r + 16'h1;
			if (prog_last)
				busy_r <= 1'b0;
		end else if (cs_rise && st_r == srp_d_pdata && bitc_r == 3'h0 && got_r && wlatch_r) begin
			busy_r <= 1'b1;
			cnt_r  <= 16'h0;
			preg_r <= reg_r;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n)
			wlatch_r <= 1'b0;
		else if (wren_ok)
			wlatch_r <= 1'b1;
		else if (prog_last)
			wlatch_r <= 1'b0;
	end

	// Lock bits only ever gain ones
	always_ff @(posedge clock) begin
		if (!reset_n)
			lock_r <= `SRP_LOCK_RST;
		else
			lock_r <= lock_r | lock_set;
	end

	// Staging keeps the last byte seen for each offset
	always_ff @(posedge clock) begin
		if (!reset_n)
			sval_r <= '0;
		else if (prog_ok)
			sval_r <= '0;
		else if (byte_done && st_r == srp_d_pdata)
			sval_r[byte_r] <= 1'b1;
	end

	always_ff @(posedge clock) begin
		if (byte_done && st_r == srp_d_pdata)
			stage_r[byte_r] <= nb;
	end

	// Programming only clears bits, like a real cell; reset models a fresh part
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			for (int i = 0; i < `SRP_NREGS * NB; i++)
				mem_r[i] <= 8'hff;
		end else if (busy_r && cnt_r[15:8] == 8'h00 && sval_r[cnt_r[7:0]])
			mem_r[{preg_r, cnt_r[7:0]}] <= mem_r[{preg_r, cnt_r[7:0]}] & stage_r[cnt_r[7:0]];
	end
endmodule : srp_dev
`default_nettype wire

// ### testbench/srp_chk.sv
// Concurrent checks on the serial link and the device status outputs.
// Instantiated beside the link interface; one system clock domain.
`timescale 1ns/1ps
`default_nettype none
module srp_chk #(
	parameter int PROG_CYCLES = 1024	// Self-timed program length
) (
	input wire logic       clock,              // System clock
	input wire logic       reset_n,            // Synchronous reset
	input wire logic       cs_n,               // Select
	input wire logic       sclk,               // Serial clock
	input wire logic       so,                 // Device data
	input wire logic       so_oe_n,            // Device drive enable
	input wire logic       busy,               // Self-timed cycle
	input wire logic       write_enable_latch, // Write enable latch
	input wire logic [2:0] otp_lock_bits       // Lock state
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	int busy_cnt_r;
	// A counter, since the program time is far beyond a delay range
	always_ff @(posedge clock) begin
		busy_cnt_r <= (busy && reset_n) ? busy_cnt_r + 1 : 0;
	end
	property p_lock_keep;
		$past(reset_n) |-> (otp_lock_bits & $past(otp_lock_bits)) == $past(otp_lock_bits);
	endproperty
	a_lock_keep: assert property (p_lock_keep) else $error("lock bit cleared");
	// The latch is set by the eighth command bit, so select is still low then
	property p_latch_rise;
		$rose(write_enable_latch) |-> !cs_n && !$past(busy);
	endproperty
	a_latch_rise: assert property (p_latch_rise) else $error("latch set while busy or idle");
	property p_busy_rise;
		$rose(busy) |-> cs_n && write_enable_latch;
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("bad start");
	property p_busy_end;
		$fell(busy) |-> ##[0:2] !write_enable_latch;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("latch kept after cycle");
	property p_busy_min;
		$rose(busy) |-> busy [*8];
	endproperty
	a_busy_min: assert property (p_busy_min) else $error("busy too short");
	property p_busy_max;
		busy_cnt_r <= PROG_CYCLES + 8;
	endproperty
	a_busy_max: assert property (p_busy_max) else $error("busy too long");
	property p_so_fall;
		!so_oe_n && !$past(so_oe_n) && so != $past(so) |-> !sclk;
	endproperty
	a_so_fall: assert property (p_so_fall) else $error("data moved with clock high");
	property p_so_idle;
		cs_n [*8] |-> so_oe_n;
	endproperty
	a_so_idle: assert property (p_so_idle) else $error("data driven while idle");
	property p_oe_frame;
		$fell(so_oe_n) |-> !cs_n;
	endproperty
	a_oe_frame: assert property (p_oe_frame) else $error("drive outside frame");
	property p_cs_rel;
		$rose(cs_n) |-> ##[1:8] so_oe_n;
	endproperty
	a_cs_rel: assert property (p_cs_rel) else $error("drive kept after select");
endmodule : srp_chk
`default_nettype wire

// ### testbench/security_register_program_read_test.sv
// Bench: host end and device end joined over the link, host driven over Wishbone.
// Uses a short write-accept delay; lock pins are pulsed by the bench.
`timescale 1ns/1ps
`default_nettype none
module security_register_program_read_test;
	localparam int PC = 3000;
	logic        clock, reset_n, cyc, stb, we, mon, flg_req, oe_busy;
	logic [7:0]  adr, rnd;
	logic [31:0] wdat, dummy;
	logic [2:0]  lock_set;
	logic [7:0]  mdl [0:767];
	logic [31:0] exp_q [$];
	logic [5:0]  flg_q [$];
	logic [5:0]  msk_q [$];
	int          err_count, comparisons;
	wire  [31:0] wb_dat;
	wire         wb_ack, busy, wlatch;
	wire  [2:0]  locks;
	wire  [5:0]  flg_now = {oe_busy, locks, busy, wlatch};
	srp_spi_if spi ();
	srp_host #(.HALF(16), .WAD_CYCLES(200), .FIFO_DEPTH(16)) srp_host_inst (.clock(clock),
		.reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .spi(spi));
	srp_dev #(.PROG_CYCLES(PC)) srp_dev_inst (.clock(clock), .reset_n(reset_n),
		.lock_set(lock_set), .otp_lock_bits(locks), .busy(busy),
		.write_enable_latch(wlatch), .spi(spi));
	srp_chk #(.PROG_CYCLES(PC)) srp_chk_inst (.clock(clock), .reset_n(reset_n),
		.cs_n(spi.cs_n), .sclk(spi.sclk), .so(spi.so), .so_oe_n(spi.so_oe_n),
		.busy(busy), .write_enable_latch(wlatch), .otp_lock_bits(locks));
	always #2 clock = ~clock;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	function automatic int idx(input logic [23:0] a, input int i);
		return (int'(a[13:12]) - 1) * 256 + (int'(a[7:0]) + i) % 256;
	endfunction : idx
	task automatic fail(input string m);
		err_count++;
		$display("mismatch at %0t: %s", $time, m);
	endtask : fail
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) fail($sformatf("read %h expected %h", g, e));
	endtask : cmp_word
	task automatic cmp_flags(input logic [5:0] e, input logic [5:0] m, input logic [5:0] g);
		comparisons++;
		if ((g & m) !== e) fail($sformatf("flags %b expected %b", g & m, e));
	endtask : cmp_flags
	always @(posedge clock) begin
		if (mon && wb_ack === 1'b1) cmp_word(exp_q.pop_front(), wb_dat);
		if (flg_req) cmp_flags(flg_q.pop_front(), msk_q.pop_front(), flg_now);
		// The only status read here runs with the device idle, so the device must never drive while busy
		if (busy === 1'b1 && spi.so_oe_n === 1'b0) oe_busy <= 1'b1;
	end
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
		int n;
		n = 0;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		mon <= c;
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack !== 1'b1 && n < 4000);
		dummy = wb_dat;
		cyc <= 1'b0;
		stb <= 1'b0;
		mon <= 1'b0;
		if (n >= 4000) fail("no acknowledge");
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 1'b0);
	endtask : wr
	task automatic chkrd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		wb(1'b0, a, 32'h0, 1'b1);
	endtask : chkrd
	task automatic flags(input logic [5:0] e, input logic [5:0] m);
		flg_q.push_back(e);
		msk_q.push_back(m);
		@(posedge clock);
		flg_req <= 1'b1;
		@(posedge clock);
		flg_req <= 1'b0;
	endtask : flags
	task automatic poll(input int b, input logic v);
		int n;
		n = 0;
		do begin
			wb(1'b0, 8'h14, 32'h0, 1'b0);
			n++;
		end while (dummy[b] !== v && n < 3000);
		if (n >= 3000) fail("status stuck");
	endtask : poll
	task automatic go(input logic [1:0] c, input logic [23:0] a, input int n);
		wr(8'h04, {8'h00, a});
		wr(8'h08, n);
		wr(8'h00, {29'h0, c, 1'b1});
	endtask : go
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < PC + 100) begin
			@(posedge clock);
			n++;
		end
		if (n >= PC + 100) fail("busy stuck");
	endtask : wait_idle
	task automatic prog(input logic [23:0] a, input int n, input logic ok);
		wr(8'h04, {8'h00, a});
		wr(8'h08, n);
		for (int i = 0; i < n; i++) begin
			// Sixteen words fill the buffer; later pushes stall until the link drains it
			if (i == 16) begin
				chkrd(8'h14, 32'h2);
				wr(8'h00, 32'h3);
			end
			rnd = lfsr(rnd);
			wr(8'h0c, {24'h0, rnd});
			if (ok) mdl[idx(a, i)] &= rnd;
		end
		if (n <= 16) wr(8'h00, 32'h3);
		poll(0, 1'b0);
	endtask : prog
	task automatic rdreg(input logic [23:0] a, input int n, input logic chk);
		go(2'd2, a, n);
		for (int i = 0; i < n; i++) begin
			poll(2, 1'b1);
			if (chk) chkrd(8'h10, {24'h0, mdl[idx(a, i)]});
			else wb(1'b0, 8'h10, 32'h0, 1'b0);
		end
		poll(0, 1'b0);
	endtask : rdreg
	task automatic wren();
		go(2'd0, 24'h0, 1);
		poll(0, 1'b0);
	endtask : wren
	initial begin
		clock = 1'b0;
		reset_n = 1'b0;
		{cyc, stb, we, mon, flg_req, oe_busy} = 6'h00;
		adr = 8'h00;
		wdat = 32'h0;
		lock_set = 3'h0;
		rnd = 8'd90;
		for (int i = 0; i < 768; i++) mdl[i] = 8'hff;
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		poll(1, 1'b1);
		prog(24'h001010, 1, 1'b0);
		flags(6'h00, 6'h3f);
		$display("test no_wren done");
		wren();
		flags(6'h01, 6'h3f);
		prog(24'h0010f0, 20, 1'b1);
		flags(6'h02, 6'h02);
		wait_idle();
		flags(6'h00, 6'h3f);
		rdreg(24'h0010ef, 22, 1'b1);
		$display("test wrap done");
		wren();
		prog(24'h004000, 1, 1'b0);
		flags(6'h01, 6'h3f);
		$display("test bad_addr done");
		@(posedge clock);
		lock_set <= 3'b010;
		@(posedge clock);
		lock_set <= 3'b000;
		prog(24'h002000, 2, 1'b0);
		flags(6'h09, 6'h3f);
		rdreg(24'h002000, 2, 1'b1);
		// Status byte: lock of register two and the latch, device idle
		go(2'd3, 24'h0, 1);
		poll(2, 1'b1);
		chkrd(8'h10, 32'h0a);
		poll(0, 1'b0);
		$display("test lock done");
		prog(24'h003020, 2, 1'b1);
		flags(6'h0a, 6'h3e);
		rdreg(24'h003020, 1, 1'b0);
		flags(6'h0a, 6'h3e);
		wait_idle();
		flags(6'h08, 6'h3f);
		rdreg(24'h003020, 2, 1'b1);
		$display("test busy_read done");
		print_verdict();
	end
	initial begin
		repeat (90000) @(posedge clock);
		fail("watchdog expired");
		print_verdict();
	end
endmodule : security_register_program_read_test
`default_nettype wire
